// ==== fer_defs.vh ====
// Purpose: constants of the fp exception and rounding unit
// Assumes: included by bare name from every design file
// Notes: offsets are byte addresses on the plain register port
`ifndef FER_DEFS_VH
`define FER_DEFS_VH
// register offsets
`define FER_SR_OFS 4'h0
`define FER_FLG_OFS 4'h4
// reset values
`define FER_SR_RST 32'h0000_0000
`define FER_FLG_RST 32'h0000_0000
// writable bits of the exception register, the rest reads as zero
`define FER_FLG_MASK 32'h0000_1f1f
// status fields
`define FER_RND_HI 14
`define FER_RND_LO 13
`define FER_TE_HI 12
`define FER_TE_LO 8
// exception register fields
`define FER_ACC_HI 4
`define FER_ACC_LO 0
`define FER_ACT_HI 12
`define FER_ACT_LO 8
// exception vector bits
`define FER_X_INV 4
`define FER_X_DZ 3
`define FER_X_OVF 2
`define FER_X_UNF 1
`define FER_X_INX 0
// rounding modes
`define FER_RM_NEAR 2'h0
`define FER_RM_ZERO 2'h1
`define FER_RM_MINF 2'h2
`define FER_RM_PINF 2'h3
// not-a-number test field of the exponent word
`define FER_NAN_HI 30
`define FER_NAN_LO 19
`define FER_NAN_ONES 12'hfff
// operation codes
`define FER_OP_ADD 4'h0
`define FER_OP_SUB 4'h1
`define FER_OP_MUL 4'h2
`define FER_OP_DIV 4'h3
`define FER_OP_CVTI 4'h4
`define FER_OP_CVTF 4'h5
`define FER_OP_CMP 4'h6
`define FER_OP_CMPU 4'h7
`define FER_OP_MOVE 4'h8
`define FER_OP_ABS 4'h9
`define FER_OP_NEG 4'ha
`define FER_OP_SQRT 4'hb
// special magnitudes, sign bit clear
`define FER_S_INF 32'h7f80_0000
`define FER_S_MAX 32'h7f7f_ffff
`define FER_D_INF 64'h7ff0_0000_0000_0000
`define FER_D_MAX 64'h7fef_ffff_ffff_ffff
`endif

// ==== fer_nan_class.v ====
// Purpose: classify one exponent word as quiet or signaling nan
// Assumes: word is the operand word that carries the exponent
// Notes: purely combinational
`timescale 1ns/1ns
`include "fer_defs.vh"
module fer_nan_class (
  // operand
  input wire [31:0] word_i,
  // class
  output wire nan_o,
  output wire snan_o
);

// RULE5 exponent ones
assign nan_o = (word_i[`FER_NAN_HI:`FER_NAN_LO] == `FER_NAN_ONES);
// RULE6 bit zero flavour
assign snan_o = nan_o & word_i[0];

endmodule

// ==== fer_ovf_pick.v ====
// Purpose: pick the delivered value of an untrapped overflow or infinity
// Assumes: single results sit in the upper word, lower word zero
// Notes: purely combinational
`timescale 1ns/1ns
`include "fer_defs.vh"
module fer_ovf_pick (
  // selection
  input wire [1:0] rmode_i,
  input wire sign_i,
  input wire dbl_i,
  input wire force_inf_i,
  // value
  output wire [63:0] val_o
);

reg to_inf;
wire [63:0] mag;

// RULE13 mode and sign
always @* begin
  case (rmode_i)
    `FER_RM_NEAR: to_inf = 1'b1;
    `FER_RM_ZERO: to_inf = 1'b0;
    `FER_RM_MINF: to_inf = sign_i;
    `FER_RM_PINF: to_inf = ~sign_i;
    default: to_inf = 1'b1;
  endcase
end

assign mag = dbl_i ? ((to_inf | force_inf_i) ? `FER_D_INF : `FER_D_MAX) :
  {((to_inf | force_inf_i) ? `FER_S_INF : `FER_S_MAX), 32'h0000_0000};
assign val_o = {sign_i, mag[62:0]};

endmodule

// ==== fer_unit.v ====
// Purpose: fp exception detection, flag update and destination control
// Assumes: arithmetic datapath supplies operand classes and rounding facts
// Notes: one operation is judged per OP_VALID_I; answers one cycle later
//
// Behaviour
// [RULE1] status bits 14..13 choose the rounding mode in four codes.
// [RULE2] status bits 12..8 enable traps: invalid, divzero, overflow, underflow, inexact.
// [RULE3] accrued flags in bits 4..0, actual flags in bits 12..8.
// [RULE4] reserved exception register bits stay zero, software writes them zero.
// [RULE5] an operand is a nan when exponent word bits 30..19 are ones.
// [RULE6] nan bit zero clear is quiet, set is signaling; 18..1 payload.
// [RULE7] only compares update the processor condition flags.
// [RULE8] inexact rises on an unrepresentable result or on overflow.
// [RULE9] an enabled trap keeps destination and sources untouched.
// [RULE10] untrapped inexact still writes the rounded or overflowed result.
// [RULE11] overflow when the unbounded rounded result exceeds the largest finite.
// [RULE12] overflow also raises inexact and sets its flag.
// [RULE13] untrapped overflow value follows rounding mode and result sign.
// [RULE14] divide by zero needs a zero divisor and finite nonzero dividend.
// [RULE15] untrapped divide by zero delivers a correctly signed infinity.
// [RULE16] invalid on inf minus inf, zero times inf, bad divides, conversions, compares, sqrt.
// [RULE17] signaling nan in any arithmetic op is invalid, a move is not.
// [RULE18] untrapped invalid signals the unimplemented exception, no nan written.
// [RULE19] with underflow trap on, any tiny result signals underflow.
// [RULE20] with underflow trap off, underflow needs tininess and accuracy loss.
// [RULE21] untrapped sets accrued flag; trapped sets actual, clears others.
// [RULE22] overflow or underflow trap wins over inexact; inexact accrued still set.
`timescale 1ns/1ns
`include "fer_defs.vh"
module fer_unit (
  // clock and reset
  input wire MCLK_I,
  input wire NRST_I,
  // register port
  input wire [3:0] REG_ADDR_I,
  input wire [31:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output wire [31:0] REG_RDATA_O,
  // operation from the datapath
  input wire OP_VALID_I,
  input wire [3:0] OP_CODE_I,
  input wire OP_DBL_I,
  input wire [31:0] OPA_HI_I,
  input wire [31:0] OPB_HI_I,
  input wire OPA_ZERO_I,
  input wire OPA_INF_I,
  input wire OPB_ZERO_I,
  input wire OPB_INF_I,
  // rounding facts from the datapath
  input wire RES_SIGN_I,
  input wire RES_INEXACT_I,
  input wire RES_OVF_I,
  input wire RES_TINY_I,
  input wire RES_LOSS_I,
  input wire CVT_UNREP_I,
  // controls to the datapath
  output wire [1:0] ROUND_SEL_O,
  // verdict, one cycle after the operation
  output wire DONE_O,
  output wire DEST_WE_O,
  output wire SUBST_O,
  output wire [31:0] SUBST_HI_O,
  output wire [31:0] SUBST_LO_O,
  output wire TRAP_O,
  output wire UNIMPL_O,
  output wire CC_WE_O,
  output wire [4:0] EXC_O
);

// ****************************************
// operation kind
// ****************************************

function is_arith;
  input [3:0] op;
  begin
    is_arith = (op != `FER_OP_MOVE) && (op != `FER_OP_CMPU);
  end
endfunction

wire arith = is_arith(OP_CODE_I);
wire is_cmp = (OP_CODE_I == `FER_OP_CMP) || (OP_CODE_I == `FER_OP_CMPU);
// compares never round, so they raise nothing but unordered
wire rounds = is_arith(OP_CODE_I) && !is_cmp;
wire op_add = (OP_CODE_I == `FER_OP_ADD);
wire op_sub = (OP_CODE_I == `FER_OP_SUB);
wire op_mul = (OP_CODE_I == `FER_OP_MUL);
wire op_div = (OP_CODE_I == `FER_OP_DIV);
wire op_cvti = (OP_CODE_I == `FER_OP_CVTI);
wire op_cmp = (OP_CODE_I == `FER_OP_CMP);
wire op_sqrt = (OP_CODE_I == `FER_OP_SQRT);

// ****************************************
// registers
// ****************************************

reg [31:0] sr_r;
reg [31:0] sr_nxt;
reg [31:0] flg_r;
reg [31:0] flg_nxt;
reg [31:0] rdata_r;
reg [31:0] rdata_nxt;

// RULE1 rounding field
assign ROUND_SEL_O = sr_r[`FER_RND_HI:`FER_RND_LO];

// RULE2 trap enables
wire [4:0] trap_en = sr_r[`FER_TE_HI:`FER_TE_LO];

// ****************************************
// operand classes
// ****************************************

wire a_nan;
wire a_snan;
wire b_nan;
wire b_snan;

fer_nan_class u_cls_a (
  .word_i(OPA_HI_I),
  .nan_o(a_nan),
  .snan_o(a_snan)
);

fer_nan_class u_cls_b (
  .word_i(OPB_HI_I),
  .nan_o(b_nan),
  .snan_o(b_snan)
);

wire a_sign = OPA_HI_I[31];
wire b_sign = OPB_HI_I[31];
wire unordered = a_nan | b_nan;
// single-operand ops carry no second operand worth testing
wire one_src = op_sqrt || (OP_CODE_I == `FER_OP_ABS) ||
  (OP_CODE_I == `FER_OP_NEG) || op_cvti || (OP_CODE_I == `FER_OP_CVTF);
wire any_snan = a_snan | (b_snan & ~one_src);
wire a_finite_nz = ~OPA_ZERO_I & ~OPA_INF_I & ~a_nan;

// ****************************************
// exception detection
// ****************************************

reg [4:0] raised;
reg inv_cause;

always @* begin
  inv_cause = 1'b0;
  // RULE17 signaling operand
  if (arith && any_snan) begin
    inv_cause = 1'b1;
  end
  // RULE16 magnitude subtraction of infinities
  if (OPA_INF_I && OPB_INF_I && !unordered) begin
    if ((op_add && (a_sign != b_sign)) || (op_sub && (a_sign == b_sign))) begin
      inv_cause = 1'b1;
    end
  end
  // RULE16 zero times infinity
  if (op_mul && ((OPA_ZERO_I && OPB_INF_I) || (OPA_INF_I && OPB_ZERO_I))) begin
    inv_cause = 1'b1;
  end
  // RULE16 zero over zero, inf over inf
  if (op_div && ((OPA_ZERO_I && OPB_ZERO_I) || (OPA_INF_I && OPB_INF_I))) begin
    inv_cause = 1'b1;
  end
  // RULE16 conversion to fixed point
  if (op_cvti && (CVT_UNREP_I || OPA_INF_I || a_nan)) begin
    inv_cause = 1'b1;
  end
  // RULE16 ordered compare of unordered pair
  if (op_cmp && unordered) begin
    inv_cause = 1'b1;
  end
  // RULE16 negative square root
  if (op_sqrt && a_sign && !OPA_ZERO_I && !a_nan) begin
    inv_cause = 1'b1;
  end
  raised = 5'h00;
  raised[`FER_X_INV] = inv_cause;
  // RULE14 finite nonzero over zero
  raised[`FER_X_DZ] = op_div && OPB_ZERO_I && a_finite_nz && !b_nan;
  // RULE11 unbounded rounded magnitude too large
  raised[`FER_X_OVF] = rounds && !inv_cause && RES_OVF_I;
  // RULE19 tininess alone when trapping
  // RULE20 tininess and loss when not
  raised[`FER_X_UNF] = rounds && !inv_cause && RES_TINY_I &&
    (trap_en[`FER_X_UNF] || RES_LOSS_I);
  // RULE8 RULE12 inexact with overflow
  raised[`FER_X_INX] = rounds && !inv_cause && (RES_INEXACT_I || RES_OVF_I);
  if (raised[`FER_X_DZ]) begin
    raised[`FER_X_OVF] = 1'b0;
    raised[`FER_X_UNF] = 1'b0;
    raised[`FER_X_INX] = 1'b0;
  end
end

// ****************************************
// trap decision
// ****************************************

reg [4:0] trap_hit;
reg [4:0] acc_set;

always @* begin
  trap_hit = raised & trap_en;
  acc_set = raised & ~trap_en;
  // RULE22 overflow or underflow trap first
  if (trap_hit[`FER_X_OVF] || trap_hit[`FER_X_UNF]) begin
    trap_hit[`FER_X_INX] = 1'b0;
    acc_set[`FER_X_INX] = raised[`FER_X_INX];
  end
end

wire take_trap = OP_VALID_I && (trap_hit != 5'h00);
// RULE18 no quiet nan is ever built
wire unimpl = OP_VALID_I && raised[`FER_X_INV] && !trap_en[`FER_X_INV];

// ****************************************
// substitute result
// ****************************************

wire [63:0] pick_val;
wire dz_path = raised[`FER_X_DZ];

// RULE13 overflow value
// RULE15 signed infinity on divide by zero
fer_ovf_pick u_pick (
  .rmode_i(sr_r[`FER_RND_HI:`FER_RND_LO]),
  .sign_i(dz_path ? (a_sign ^ b_sign) : RES_SIGN_I),
  .dbl_i(OP_DBL_I),
  .force_inf_i(dz_path),
  .val_o(pick_val)
);

// ****************************************
// register write and read
// ****************************************

wire wr_sr = REG_WR_I && (REG_ADDR_I == `FER_SR_OFS);
wire wr_flg = REG_WR_I && (REG_ADDR_I == `FER_FLG_OFS);

always @* begin
  sr_nxt = wr_sr ? REG_WDATA_I : sr_r;
end

// hardware sets win over a software write in the same cycle
always @* begin
  // RULE4 reserved bits forced zero
  flg_nxt = wr_flg ? (REG_WDATA_I & `FER_FLG_MASK) : flg_r;
  if (OP_VALID_I) begin
    // RULE3 RULE21 accrued flags
    flg_nxt[`FER_ACC_HI:`FER_ACC_LO] = flg_nxt[`FER_ACC_HI:`FER_ACC_LO] | acc_set;
  end
  if (take_trap) begin
    // RULE3 RULE21 actual flags
    flg_nxt[`FER_ACT_HI:`FER_ACT_LO] = trap_hit;
  end
end

always @* begin
  rdata_nxt = 32'h0000_0000;
  if (REG_RD_I) begin
    case (REG_ADDR_I)
      `FER_SR_OFS: rdata_nxt = sr_r;
      `FER_FLG_OFS: rdata_nxt = flg_r & `FER_FLG_MASK;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end
end

assign REG_RDATA_O = rdata_r;

// ****************************************
// verdict registers
// ****************************************

reg done_r;
reg dest_we_r;
reg subst_r;
reg [63:0] subst_val_r;
reg trap_r;
reg unimpl_r;
reg cc_we_r;
reg [4:0] exc_r;

// RULE9 trapped destination untouched
// RULE10 untrapped inexact writes result
wire dest_we_nxt = OP_VALID_I && !is_cmp && !take_trap && !raised[`FER_X_INV];
wire subst_nxt = dest_we_nxt && (raised[`FER_X_OVF] || dz_path);
// RULE7 condition flags on compare only
wire cc_we_nxt = OP_VALID_I && is_cmp;

always @(posedge MCLK_I or negedge NRST_I) begin
  if (!NRST_I) begin
    sr_r <= `FER_SR_RST;
    flg_r <= `FER_FLG_RST;
    rdata_r <= 32'h0000_0000;
    done_r <= 1'b0;
    dest_we_r <= 1'b0;
    subst_r <= 1'b0;
    subst_val_r <= 64'h0000_0000_0000_0000;
    trap_r <= 1'b0;
    unimpl_r <= 1'b0;
    cc_we_r <= 1'b0;
    exc_r <= 5'h00;
  end else begin
    sr_r <= sr_nxt;
    flg_r <= flg_nxt;
    rdata_r <= rdata_nxt;
    done_r <= OP_VALID_I;
    dest_we_r <= dest_we_nxt;
    subst_r <= subst_nxt;
    subst_val_r <= subst_nxt ? pick_val : 64'h0000_0000_0000_0000;
    trap_r <= take_trap;
    unimpl_r <= unimpl;
    cc_we_r <= cc_we_nxt;
    exc_r <= OP_VALID_I ? raised : 5'h00;
  end
end

assign DONE_O = done_r;
assign DEST_WE_O = dest_we_r;
assign SUBST_O = subst_r;
assign SUBST_HI_O = subst_val_r[63:32];
assign SUBST_LO_O = subst_val_r[31:0];
assign TRAP_O = trap_r;
assign UNIMPL_O = unimpl_r;
assign CC_WE_O = cc_we_r;
assign EXC_O = exc_r;

endmodule

// ==== fer_unit_chk_sva.sv ====
// Purpose: port checker of fer_unit
// Assumes: bound onto every fer_unit instance
// Notes: the verdict lags its operation by one cycle
`timescale 1ns/1ns
`include "fer_defs.vh"
module fer_unit_chk (
  // clock and reset
  input wire MCLK_I,
  input wire NRST_I,
  // register port
  input wire [3:0] REG_ADDR_I,
  input wire [31:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [31:0] REG_RDATA_O,
  // operation
  input wire OP_VALID_I,
  input wire [3:0] OP_CODE_I,
  input wire [31:0] OPA_HI_I,
  input wire OPA_ZERO_I,
  input wire OPA_INF_I,
  input wire OPB_ZERO_I,
  // verdict
  input wire [1:0] ROUND_SEL_O,
  input wire DONE_O,
  input wire DEST_WE_O,
  input wire SUBST_O,
  input wire TRAP_O,
  input wire UNIMPL_O,
  input wire CC_WE_O,
  input wire [4:0] EXC_O
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);
  property p_done; OP_VALID_I |=> DONE_O; endproperty
  a_done: assert property (p_done) else $error("verdict missing");
  property p_idle; !OP_VALID_I |=> !DONE_O && !TRAP_O && EXC_O == 5'h0; endproperty
  a_idle: assert property (p_idle) else $error("verdict without op");
  property p_cc; CC_WE_O |-> DONE_O && $past(OP_CODE_I) inside {4'h6, 4'h7}; endproperty
  a_cc: assert property (p_cc) else $error("flags hit by non compare");
  property p_ovfi; DONE_O && EXC_O[`FER_X_OVF] |-> EXC_O[`FER_X_INX]; endproperty
  a_ovfi: assert property (p_ovfi) else $error("overflow without inexact");
  property p_trap; TRAP_O |-> DONE_O && !DEST_WE_O && !SUBST_O; endproperty
  a_trap: assert property (p_trap) else $error("trap wrote result");
  property p_dz;
    OP_VALID_I && OP_CODE_I == `FER_OP_DIV && OPB_ZERO_I && !OPA_ZERO_I && !OPA_INF_I
      && OPA_HI_I[30:19] != `FER_NAN_ONES |=> EXC_O[`FER_X_DZ];
  endproperty
  a_dz: assert property (p_dz) else $error("divide by zero missed");
  property p_rnd; REG_WR_I && REG_ADDR_I == `FER_SR_OFS |=> ROUND_SEL_O == $past(REG_WDATA_I[14:13]); endproperty
  a_rnd: assert property (p_rnd) else $error("rounding select stale");
  property p_move; OP_VALID_I && OP_CODE_I == `FER_OP_MOVE |=> EXC_O == 5'h0 && DEST_WE_O; endproperty
  a_move: assert property (p_move) else $error("move raised");
  property p_unimp; UNIMPL_O |-> EXC_O[`FER_X_INV] && !TRAP_O && !DEST_WE_O; endproperty
  a_unimp: assert property (p_unimp) else $error("bad unimplemented");
  property p_resv;
    REG_RD_I && REG_ADDR_I == `FER_FLG_OFS |=> REG_RDATA_O[31:13] == 19'h0 && REG_RDATA_O[7:5] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved flag bit set");
  property p_nan; OP_VALID_I && OP_CODE_I == `FER_OP_CMP && OPA_HI_I[30:19] == `FER_NAN_ONES |=> EXC_O[4]; endproperty
  a_nan: assert property (p_nan) else $error("nan compare not invalid");
  c_trap: cover property (TRAP_O);
  c_unimp: cover property (UNIMPL_O);
  c_subst: cover property (SUBST_O);
endmodule
bind fer_unit fer_unit_chk u_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I), .OPA_HI_I(OPA_HI_I), .OPA_ZERO_I(OPA_ZERO_I),
  .OPA_INF_I(OPA_INF_I), .OPB_ZERO_I(OPB_ZERO_I), .ROUND_SEL_O(ROUND_SEL_O), .DONE_O(DONE_O),
  .DEST_WE_O(DEST_WE_O), .SUBST_O(SUBST_O), .TRAP_O(TRAP_O), .UNIMPL_O(UNIMPL_O),
  .CC_WE_O(CC_WE_O), .EXC_O(EXC_O));

// ==== tb.sv ====
// Purpose: random and corner test of fer_unit
// Assumes: verdict one cycle after each op
// Notes: rounding facts are random inputs, tiny cleared with overflow, inx to loss zeroed for cvti, compares, move, abs and neg, unrep random for cvti only
`timescale 1ns/1ns
`include "fer_defs.vh"
module tb;
  reg MCLK_I = 1'b0;
  reg NRST_I = 1'b0;
  reg [3:0] REG_ADDR_I = 4'h0;
  reg [31:0] REG_WDATA_I = 32'h0;
  reg REG_WR_I = 1'b0;
  reg REG_RD_I = 1'b0;
  reg OP_VALID_I = 1'b0;
  reg [3:0] OP_CODE_I = 4'h0;
  reg [31:0] OPA_HI_I = 32'h0;
  reg [31:0] OPB_HI_I = 32'h0;
  // dbl,azero,ainf,bzero,binf,sign,inx,ovf,tiny,loss,unrep
  reg [10:0] fl = 11'h0;
  wire [31:0] REG_RDATA_O, SUBST_HI_O, SUBST_LO_O;
  wire [1:0] ROUND_SEL_O;
  wire [4:0] EXC_O;
  wire DONE_O, DEST_WE_O, SUBST_O, TRAP_O, UNIMPL_O, CC_WE_O;
  integer failures = 0;
  integer check_count = 0;
  integer seed = 1757;
  integer i;
  reg [31:0] sr, fr, rdv, ra, rb, rf, a;
  reg [3:0] c;
  always #4 MCLK_I = ~MCLK_I;
  fer_unit u_dut (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I),
    .OP_DBL_I(fl[10]), .OPA_HI_I(OPA_HI_I), .OPB_HI_I(OPB_HI_I), .OPA_ZERO_I(fl[9]),
    .OPA_INF_I(fl[8]), .OPB_ZERO_I(fl[7]), .OPB_INF_I(fl[6]), .RES_SIGN_I(fl[5]),
    .RES_INEXACT_I(fl[4]), .RES_OVF_I(fl[3]), .RES_TINY_I(fl[2]), .RES_LOSS_I(fl[1]),
    .CVT_UNREP_I(fl[0]), .ROUND_SEL_O(ROUND_SEL_O), .DONE_O(DONE_O), .DEST_WE_O(DEST_WE_O),
    .SUBST_O(SUBST_O), .SUBST_HI_O(SUBST_HI_O), .SUBST_LO_O(SUBST_LO_O), .TRAP_O(TRAP_O),
    .UNIMPL_O(UNIMPL_O), .CC_WE_O(CC_WE_O), .EXC_O(EXC_O));
  // ********
  // checking and bus tasks
  // ********
  task chk_out(input [63:0] g, input [63:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task chk_reg(input [31:0] g, input [31:0] e);
    chk_out({32'h0, g}, {32'h0, e});
  endtask
  task finish_test;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [3:0] ad, input [31:0] d);
    begin
      @(posedge MCLK_I);
      REG_ADDR_I <= ad;
      REG_WDATA_I <= d;
      REG_WR_I <= 1'b1;
      @(posedge MCLK_I);
      REG_WR_I <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] ad);
    begin
      @(posedge MCLK_I);
      REG_ADDR_I <= ad;
      REG_RD_I <= 1'b1;
      @(posedge MCLK_I);
      REG_RD_I <= 1'b0;
      #1;
      rdv = REG_RDATA_O;
    end
  endtask
  task set_sr(input [31:0] d);
    begin
      wr(`FER_SR_OFS, d);
      sr = d;
      #1;
      chk_out(ROUND_SEL_O, d[14:13]);
      rd_reg(`FER_SR_OFS);
      chk_reg(rdv, d);
    end
  endtask
  // ********
  // expectation
  // ********
  function nan(input [31:0] w);
    nan = w[30:19] == `FER_NAN_ONES;
  endfunction
  function [4:0] exc_of(input [3:0] k, input [31:0] x, input [31:0] y, input [10:0] f);
    reg one, inv, dz, ar;
    begin
      one = k == `FER_OP_CVTI || k == `FER_OP_CVTF || k >= `FER_OP_ABS;
      ar = k != `FER_OP_MOVE && k != `FER_OP_CMPU && k != `FER_OP_CMP;
      inv = ar && ((nan(x) && x[0]) || (!one && nan(y) && y[0]));
      case (k)
        `FER_OP_ADD: inv = inv | f[8] & f[6] & (x[31] ^ y[31]);
        `FER_OP_SUB: inv = inv | f[8] & f[6] & (x[31] ~^ y[31]);
        `FER_OP_MUL: inv = inv | f[9] & f[6] | f[8] & f[7];
        `FER_OP_DIV: inv = inv | f[9] & f[7] | f[8] & f[6];
        `FER_OP_CVTI: inv = inv | f[0] | f[8] | nan(x);
        `FER_OP_CMP: inv = nan(x) | nan(y);
        `FER_OP_SQRT: inv = inv | x[31] & !f[9] & !nan(x);
        default: ;
      endcase
      dz = k == `FER_OP_DIV && f[7] && !f[9] && !f[8] && !nan(x) && !inv;
      ar = ar && !inv && !dz;
      exc_of = {inv, dz, ar & f[3], ar & f[2] & (sr[9] | f[1]), ar & (f[4] | f[3])};
    end
  endfunction
  function [63:0] pick(input dz, input s, input dbl);
    reg mx;
    begin
      case (sr[14:13])
        `FER_RM_NEAR: mx = 1'b0;
        `FER_RM_ZERO: mx = 1'b1;
        `FER_RM_MINF: mx = !s;
        default: mx = s;
      endcase
      mx = mx & !dz;
      if (dbl)
        pick = (mx ? `FER_D_MAX : `FER_D_INF) | {s, 63'h0};
      else
        pick = {(mx ? `FER_S_MAX : `FER_S_INF) | {s, 31'h0}, 32'h0};
    end
  endfunction
  task op(input [3:0] k, input [31:0] x, input [31:0] y, input [10:0] f);
    reg [4:0] e, h;
    reg tr;
    begin
      @(posedge MCLK_I);
      OP_CODE_I <= k;
      OPA_HI_I <= x;
      OPB_HI_I <= y;
      fl <= f;
      OP_VALID_I <= 1'b1;
      @(posedge MCLK_I);
      OP_VALID_I <= 1'b0;
      #1;
      e = exc_of(k, x, y, f);
      h = e & sr[12:8];
      if (h[2] | h[1])
        h[0] = 1'b0;
      tr = |h;
      chk_out(DONE_O, 1'b1);
      chk_out(EXC_O, e);
      chk_out(TRAP_O, tr);
      chk_out(UNIMPL_O, e[4] & !sr[12]);
      if (k != `FER_OP_CMP && k != `FER_OP_CMPU)
        chk_out(DEST_WE_O, !tr & !e[4]);
      if (!tr)
        chk_out(CC_WE_O, k == `FER_OP_CMP || k == `FER_OP_CMPU);
      if (!tr && !e[4])
        chk_out(SUBST_O, e[3] | e[2]);
      // divide by zero takes the quotient sign, overflow the datapath sign
      if (!tr && !e[4])
        chk_out({SUBST_HI_O, SUBST_LO_O}, (e[3] | e[2]) ?
          pick(e[3], e[3] ? (x[31] ^ y[31]) : f[5], f[10]) : 64'h0);
      fr[4:0] = fr[4:0] | (e & ~h);
      if (tr)
        fr[12:8] = h;
      rd_reg(`FER_FLG_OFS);
      chk_reg(rdv, fr);
    end
  endtask
  function [31:0] opnd(input [31:0] r);
    case (r[2:0])
      3'h0: opnd = {r[31], 12'hfff, r[18:0]};
      3'h1: opnd = {r[31], 31'h0};
      3'h2: opnd = {r[31], 31'h7f80_0000};
      default: opnd = {r[31:23], 1'b0, r[21:0]};
    endcase
  endfunction
  // ********
  // sequence
  // ********
  initial begin
    #200_000;
    failures = failures + 1;
    finish_test;
  end
  initial begin
    sr = 32'h0;
    fr = 32'h0;
    repeat (4) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    rd_reg(`FER_SR_OFS);
    chk_reg(rdv, `FER_SR_RST);
    rd_reg(`FER_FLG_OFS);
    chk_reg(rdv, `FER_FLG_RST);
    rd_reg(4'h8);
    chk_reg(rdv, 32'h0);
    $display("test reset done");
    set_sr(32'h0);
    op(`FER_OP_DIV, 32'h3f80_0000, 32'h0, 11'h0a0);
    op(`FER_OP_MOVE, 32'h7ff8_0001, 32'h7ff8_0001, 11'h0);
    op(`FER_OP_NEG, 32'h7ff8_0001, 32'h0, 11'h0);
    op(`FER_OP_MUL, 32'h0, 32'h7f80_0000, 11'h240);
    op(`FER_OP_ADD, 32'h0, 32'h0, 11'h004);
    set_sr(32'h0000_0700);
    op(`FER_OP_ADD, 32'h0, 32'h0, 11'h418);
    op(`FER_OP_ADD, 32'h0, 32'h0, 11'h004);
    set_sr(32'h0000_6000);
    op(`FER_OP_ADD, 32'h0, 32'h0, 11'h438);
    $display("test corner done");
    for (i = 0; i < 400; i = i + 1) begin
      if (i % 16 == 0)
        set_sr($random(seed));
      if (i % 50 == 7) begin
        ra = $random(seed);
        wr(`FER_FLG_OFS, ra);
        fr = ra & `FER_FLG_MASK;
      end
      ra = $random(seed);
      rb = $random(seed);
      rf = $random(seed);
      c = rf[31:28] % 4'hc;
      rf[9:6] = {ra[2:0] == 3'h1, ra[2:0] == 3'h2, rb[2:0] == 3'h1, rb[2:0] == 3'h2};
      rf[2] = rf[2] & !rf[3];
      if (c == `FER_OP_CVTI || (c > `FER_OP_CVTF && c < `FER_OP_SQRT))
        rf[4:1] = 4'h0;
      if (c != `FER_OP_CVTI)
        rf[0] = 1'b0;
      a = opnd(ra);
      if (c == `FER_OP_SQRT && nan(a))
        a[31] = 1'b0;
      op(c, a, opnd(rb), rf[10:0]);
    end
    $display("test random done");
    finish_test;
  end
endmodule
